// ==== hdl/measure_timer_regs.svh ====
// constants for the pulse measure timer channel group
// assumes inclusion by bare name from the package and the design module
`ifndef MEASURE_TIMER_REGS_SVH
`define MEASURE_TIMER_REGS_SVH
`define MT_CHANNELS      6
`define MT_CNT_W         16
`define MT_RELOAD_READ   16'hffff
`define MT_CNT_RESET     16'h0000
`define MT_MODE_W        2
`define MT_MODE_TIMER    2'h0
`define MT_MODE_EVENT    2'h1
`define MT_MODE_MEASURE  2'h2
`define MT_PRESCALE      8'h01
`endif

// ==== hdl/measure_timer_pkg.sv ====
// types for the pulse measure timer channel group
// assumes measure_timer_regs.svh is on the include path
`include "measure_timer_regs.svh"
package measure_timer_pkg;
  typedef enum logic [1:0]
  {
    mode_timer   = 2'b00,
    mode_event   = 2'b01,
    mode_measure = 2'b10,
    mode_unused  = 2'b11
  } mode_t;
  typedef enum logic [1:0]
  {
    ph_halted  = 2'b00,
    ph_waiting = 2'b01,
    ph_running = 2'b10
  } phase_t;
endpackage : measure_timer_pkg

// ==== hdl/measure_timer.sv ====
// one 16-bit timer channel: timer, event counter and pulse period or width measurement
// assumes synchronous inputs, a single 100 MHz clock, one instance per channel
// assumes software loads the counter before every start
// assumes the group of six channels is built from six instances side by side
`timescale 1ns/1ns
`include "measure_timer_regs.svh"

////////////////////////////////////////////////////////////////////////
// behaviour in short
// - timer and event modes count down and reload from the preset at zero
// - measurement counts up from whatever the counter held at start
// - each valid edge captures the running count and restarts from zero
// - the first capture after start is stale and raises no request
// - an up-count wrap sets the overflow flag and raises a request
// - the overflow flag clears only on a mode write armed by a later tick
// - mode code 3 is idle: the counter neither counts nor reloads
// limitation: no read strobe, so the read-back is sampled every cycle
// trade-off: read-back is one cycle late but comes from a flip-flop
////////////////////////////////////////////////////////////////////////


module measure_timer
  import measure_timer_pkg::*;
#(
  parameter int          CNT_W    = `MT_CNT_W,
  parameter logic [7:0]  PRESCALE = `MT_PRESCALE
)
(
  input  wire logic             clk,
  input  wire logic             rstn,
  input  wire logic             ce,
  input  wire logic             start,
  input  wire logic [1:0]       mode_sel,
  input  wire logic             width_sel,
  input  wire logic             mode_wr,
  input  wire logic             cnt_wr,
  input  wire logic [CNT_W-1:0] cnt_wdata,
  input  wire logic             pulse_in,
  output logic      [CNT_W-1:0] cnt_rdata,
  output logic      [CNT_W-1:0] reload_q,
  output logic                  overflow_q,
  output logic                  irq_q
);

  ////////////////////////////////////////////////////////////////////////
  // state
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] preset_q;
  logic [7:0]       pre_q;
  phase_t           phase_q;
  logic             pin_q;
  logic             width_q;
  logic             first_edge_q;
  logic             tick_seen_q;
  logic             start_q;

  ////////////////////////////////////////////////////////////////////////
  // constants cut to the counter width on purpose
  localparam logic [CNT_W-1:0] CNT_RESET = CNT_W'(`MT_CNT_RESET);
  localparam logic [CNT_W-1:0] RELOAD_RD = CNT_W'(`MT_RELOAD_READ);
  localparam logic [CNT_W-1:0] CNT_ONE   = {{(CNT_W-1){1'b0}}, 1'b1};
  localparam logic [CNT_W-1:0] CNT_ALL1  = {CNT_W{1'b1}};

  ////////////////////////////////////////////////////////////////////////
  // helpers
  // one count step, up for measurement, down for timer and event modes
  function automatic logic [CNT_W-1:0] step_cnt
  (
    input logic [CNT_W-1:0] val,
    input logic             up
  );
    step_cnt = up ? val + CNT_ONE : val - CNT_ONE;
  endfunction : step_cnt

  // mode decode shared by every qualifier below
  function automatic logic mode_is
  (
    input logic [1:0] sel,
    input logic [1:0] code
  );
    mode_is = (sel == code);
  endfunction : mode_is

  ////////////////////////////////////////////////////////////////////////
  // decode
  // count source and mode qualifiers
  wire       tick       = (pre_q == PRESCALE - 8'h01);
  wire       measuring  = mode_is(mode_sel, `MT_MODE_MEASURE);
  wire       event_mode = mode_is(mode_sel, `MT_MODE_EVENT);
  // code 3 is idle, so only timer and event codes count down
  wire       down_mode  = mode_is(mode_sel, `MT_MODE_TIMER) | event_mode;
  wire       running    = start & (phase_q != ph_halted);

  // pin edges against last cycle's level
  wire       rise       = pulse_in & ~pin_q;
  wire       fall       = ~pulse_in & pin_q;
  // period measures rise to rise, width measures every transition
  wire       valid_edge = width_q ? (rise | fall) : rise;
  wire       cnt_event  = event_mode ? rise : tick;
  wire       at_end     = (cnt_q == {CNT_W{1'b0}});

  // events that move the counter, raise a request or clear the overflow flag
  wire       meas_edge  = running & measuring & valid_edge;
  wire       meas_wrap  = running & measuring & tick & (cnt_q == CNT_ALL1);
  wire       reload_now = running & down_mode & cnt_event & at_end;
  wire       sel_change = running & measuring & (width_sel != width_q);
  wire       ovf_clear  = mode_wr & tick_seen_q & overflow_q;

  // request sources; the first capture after start stays silent
  wire       irq_capture = meas_edge & ~first_edge_q;
  wire       irq_d       = irq_capture | meas_wrap | sel_change | reload_now;

  // reload instant reads FFFF; halted reads give the written preset
  wire [CNT_W-1:0] rd_d = ~running ? preset_q :
                          (reload_now ? RELOAD_RD : cnt_q);

  ////////////////////////////////////////////////////////////////////////
  // prescaler, the count source
  always_ff @(posedge clk)
  begin
    if (!rstn)
      pre_q <= 8'h00;
    else if (ce)
      pre_q <= (tick | ~running) ? 8'h00 : pre_q + 8'h01;
  end

  ////////////////////////////////////////////////////////////////////////
  // phase, pin history and select tracking
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      phase_q      <= ph_halted;
      pin_q        <= 1'b0;
      width_q      <= 1'b0;
      first_edge_q <= 1'b0;
      start_q      <= 1'b0;
    end
    else if (ce)
    begin
      pin_q   <= pulse_in;
      width_q <= width_sel;
      start_q <= start;
      if (!start)
        phase_q <= ph_halted;
      else if (!start_q)
        phase_q <= ph_waiting;
      else
        phase_q <= ph_running;
      if (start & ~start_q)
        first_edge_q <= 1'b1;
      else if (meas_edge)
        first_edge_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // counter; the preset is whatever software loaded, never cleared by start
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      cnt_q    <= CNT_RESET; // software must load before start
      preset_q <= CNT_RESET;
    end
    else if (ce)
    begin
      if (cnt_wr)
        preset_q <= cnt_wdata;
      if (cnt_wr & ~running)
        cnt_q <= cnt_wdata;
      else if (meas_edge)
        cnt_q <= {CNT_W{1'b0}};
      else if (running & measuring & tick)
        cnt_q <= step_cnt(cnt_q, 1'b1); // starts from stale value
      else if (reload_now)
        cnt_q <= preset_q;
      else if (running & down_mode & cnt_event)
        cnt_q <= step_cnt(cnt_q, 1'b0);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // capture, overflow and interrupt request; the overflow set wins over its clear
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      reload_q    <= CNT_RESET;
      overflow_q  <= 1'b0;
      irq_q       <= 1'b0;
      tick_seen_q <= 1'b0;
      cnt_rdata   <= CNT_RESET;
    end
    else if (ce)
    begin
      cnt_rdata <= rd_d;
      if (meas_edge)
        reload_q <= cnt_q; // first capture is stale data
      // arm the clear only after start, overflow and then one tick
      if (!overflow_q | ~running)
        tick_seen_q <= 1'b0;
      else if (tick)
        tick_seen_q <= 1'b1;
      if (meas_wrap)
        overflow_q <= 1'b1;
      else if (ovf_clear)
        overflow_q <= 1'b0;
      // registered copy of the sources each enabled cycle; held while ce is low
      irq_q <= irq_d;
    end
  end

endmodule : measure_timer

// ==== bench/mt_assertions.sv ====
// assertions on one measure timer channel
// assumes a bind onto measure_timer, one clock
`timescale 1ns/1ns
module mt_chk (
  input wire logic        clk, rstn, ce, start, width_sel, mode_wr, cnt_wr, pulse_in, overflow_q, irq_q,
  input wire logic [1:0]  mode_sel,
  input wire logic [15:0] cnt_wdata, cnt_rdata, reload_q
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  // read-back, request and flag start cleared
  rst_zero_a: assert property ($rose(rstn) |-> !cnt_rdata && !irq_q && !overflow_q)
    else $error("reset value");
  // halted write reads back, and holds
  halt_read_a: assert property (cnt_wr && !start ##1 !start |=> cnt_rdata == $past(cnt_wdata, 2))
    else $error("read back");
  halt_hold_a: assert property ((!start && !cnt_wr) [*2] |=> $stable(cnt_rdata))
    else $error("halted drift");
  // flag clears only through a mode write
  ovf_hold_a: assert property (overflow_q && !mode_wr |=> overflow_q)
    else $error("flag lost");
  ovf_irq_a: assert property ($rose(overflow_q) |-> irq_q)
    else $error("wrap silent");
  sel_irq_a: assert property (start && $past(start) && mode_sel == 2'h2 && $changed(width_sel) |-> ##[0:2] irq_q)
    else $error("select silent");
  idle_irq_a: assert property (!start [*3] |-> !irq_q)
    else $error("idle request");
  cap_hold_a: assert property ((!start && !cnt_wr) [*2] |-> $stable(reload_q))
    else $error("capture drift");
endmodule : mt_chk

// ==== bench/pulse_src.sv ====
// pulse source on the channel input
// assumes the bench clock; level frozen while disabled
`timescale 1ns/1ns
module pulse_src #(parameter int HALF = 5) (
  input  wire logic clk,
  input  wire logic en,
  output logic      pulse_in
);
  int cnt = 0;
  initial pulse_in = 1'b0;
  // toggle every HALF ticks; shorter gaps could hide edges
  always @(posedge clk)
    if (en && ++cnt >= HALF) begin cnt = 0; pulse_in <= ~pulse_in; end
endmodule : pulse_src

// ==== bench/tb.sv ====
// self-checking bench for one measure timer channel
// assumes design, mt_chk and pulse_src compiled first
`timescale 1ns/1ns
module tb;
  logic clk = 0, rstn = 0, start = 0, width_sel = 0, mode_wr = 0, cnt_wr = 0, pen = 0, pz = 0, ce = 1;
  logic [1:0]  mode_sel = 2'h3;
  logic [15:0] cnt_wdata = 16'h0, cnt_rdata, reload_q, v;
  logic        pulse_in, overflow_q, irq_q;
  int n_fail = 0, tests_run = 0, seed = 32'h80c8, cyc = 0, ni = 0, nr = 0, ne = 0, ff = 0, i0, f0;
`define CK(nm, e, s) begin tests_run++; if ((s) !== (e)) begin n_fail++; $display("MISMATCH %s exp %0h got %0h", nm, e, s); end end
  measure_timer dut_u (.clk, .rstn, .ce, .start, .mode_sel, .width_sel, .mode_wr, .cnt_wr, .cnt_wdata,
    .pulse_in, .cnt_rdata, .reload_q, .overflow_q, .irq_q);
  pulse_src src_u (.clk, .en(pen), .pulse_in);
  always #5 clk = ~clk;
  // tallies of requests, input edges, ffff reads; cut a hang
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    pz <= pulse_in;
    ni <= ni + (irq_q === 1'b1);
    nr <= nr + (start && pulse_in && !pz);
    ne <= ne + (start && pulse_in !== pz);
    ff <= ff + (cnt_rdata === 16'hffff);
    if (cyc == 4000) begin n_fail++; give_verdict; end
  end
  task automatic step(int n);
    repeat (n) @(posedge clk);
  endtask : step
  // load counter while halted, then start in a mode
  task automatic go(logic [15:0] c, logic [1:0] m, logic w);
    @(posedge clk) begin cnt_wr <= 1; cnt_wdata <= c; width_sel <= w; end
    @(posedge clk) begin cnt_wr <= 0; mode_sel <= m; start <= 1; end
  endtask : go
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : give_verdict
  initial
  begin
    step(20);
    rstn <= 1;
    v = $random(seed);
    @(posedge clk) begin cnt_wr <= 1; cnt_wdata <= v; end
    @(posedge clk) cnt_wr <= 0;
    step(2);
    #1 `CK("halted read", v, cnt_rdata)
    $display("halted read done");
    // period then width: first edge stays silent
    for (int w = 0; w < 2; w++)
    begin
      go(16'h0, 2'h2, w[0]);
      step(2);
      i0 = ni - (w ? ne : nr);
      pen <= 1; step(60); pen <= 0; step(20);
      `CK("measure irqs", (w ? ne : nr) - 1, ni - i0)
      // pin toggles every 5 cycles: width spans 5, period 10, count restarts at 0
      `CK("captured count", w ? 16'h0004 : 16'h0009, reload_q)
      @(posedge clk) start <= 0;
    end
    $display("measure done");
    // wrap with no edges, clear flag, reselect
    go(16'hfff0, 2'h2, 1'b0);
    step(24);
    #1 `CK("overflow set", 1'b1, overflow_q)
    i0 = ni;
    @(posedge clk) mode_wr <= 1;
    @(posedge clk) begin mode_wr <= 0; width_sel <= 1; end
    step(3);
    #1 `CK("overflow clear", 1'b0, overflow_q)
    `CK("select irq", 1, ni - i0)
    @(posedge clk) start <= 0;
    $display("overflow done");
    i0 = ni; f0 = ff;
    go(16'h0004, 2'h0, 1'b0);
    step(30);
    `CK("reload read", 1'b1, ff > f0)
    `CK("timer irq", 1'b1, ni - i0 > 3)
    $display("timer done");
    // clock enable low freezes the running count
    @(posedge clk) ce <= 0;
    step(2);
    v = cnt_rdata;
    step(5);
    #1 `CK("frozen read", v, cnt_rdata)
    @(posedge clk) ce <= 1;
    @(posedge clk) start <= 0;
    $display("freeze done");
    // event counter: preset 3 reloads on every fourth rise
    go(16'h0003, 2'h1, 1'b0);
    step(2);
    i0 = ni; f0 = nr;
    pen <= 1; step(90); pen <= 0; step(10);
    `CK("event irqs", (nr - f0) / 4, ni - i0)
    $display("event done");
    give_verdict;
  end
endmodule : tb
////////////////////////////////////////
bind measure_timer mt_chk chk_u (.*);
